/* File: sba_agent.sv */
// software-driven agent: channel table, requests, locks, splits
// assumes a simple register port on mclk; read data one cycle after strobe
module sba_agent (
  input wire logic mclk,
  input wire logic reset,
  sba_if.agent bus,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [1:0] htrans_in,
  input wire logic hburst_last_in,
  input wire logic hready_in,
  input wire logic [1:0] hresp_in,
  input wire logic [15:0] hsplit_in,
  input wire logic [15:0] split_busy_in,
  input wire logic [15:0] to_split_in,
  input wire logic cpu_ifetch_in,
  input wire logic cpu_data_in,
  input wire logic cpu_ext_in
);
  ////////////////////////////////////////////////////////////////////////////
  logic [127:0] request_channel_config;
  logic [15:0] req_r;
  logic [15:0] lock_r;
  logic tmo_sel;
  logic [31:0] rdata_r;

  wire logic [1:0] cfg_word = addr[1:0];
  wire logic cfg_hit = (addr[3:2] == 2'h0);
  wire logic [31:0] status_word = {14'h0, bus.timeout, bus.hmastlock, bus.hmaster_data,
    bus.hmaster, bus.hgrant[7:0]};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      // only the cpu channel starts enabled, at full rate
      request_channel_config <= {{15{sba_pkg::CFG_OFF_RESET}}, sba_pkg::CFG_CPU_RESET}; // [R7]
      req_r <= 16'h0000;
      lock_r <= 16'h0000;
      tmo_sel <= 1'b0;
    end else if (wr) begin
      if (cfg_hit) begin
        // whole word written at once so shared channels change together
        request_channel_config[cfg_word*32 +: 32] <= wdata; // [R13]
      end else if (addr == sba_pkg::REG_REQ) begin
        req_r <= wdata[15:0];
      end else if (addr == sba_pkg::REG_LOCK) begin
        lock_r <= wdata[15:0];
      end else if (addr == sba_pkg::REG_TMO) begin
        tmo_sel <= wdata[0];
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h0;
    end else if (rd) begin
      if (cfg_hit) begin
        rdata_r <= request_channel_config[cfg_word*32 +: 32];
      end else if (addr == sba_pkg::REG_REQ) begin
        rdata_r <= {16'h0, req_r};
      end else if (addr == sba_pkg::REG_LOCK) begin
        rdata_r <= {16'h0, lock_r};
      end else if (addr == sba_pkg::REG_STATUS) begin
        rdata_r <= status_word;
      end else if (addr == sba_pkg::REG_TMO) begin
        rdata_r <= {31'h0, tmo_sel};
      end else begin
        rdata_r <= 32'h0;
      end
    end else begin
      rdata_r <= 32'h0;
    end
  end
  assign rdata = rdata_r;

  // default master holds IDLE while granted; others pass the caller's transfer
  wire logic dflt_owner = (bus.hmaster == sba_pkg::DEFAULT_MASTER);
  assign bus.htrans = dflt_owner ? sba_pkg::HTRANS_IDLE : htrans_in; // [R17]
  assign bus.hburst_last = hburst_last_in;
  assign bus.hready = hready_in; // [R10] [R12]
  assign bus.hresp = hresp_in;
  assign bus.hsplit = hsplit_in; // [R20]
  assign bus.slave_split_busy = split_busy_in;
  assign bus.req_to_split_slave = to_split_in;
  assign bus.hbusreq = req_r;
  assign bus.hlock = lock_r;
  assign bus.chan_cfg = request_channel_config;
  assign bus.cpu_ifetch_req = cpu_ifetch_in;
  assign bus.cpu_data_req = cpu_data_in;
  assign bus.cpu_ext_mem = cpu_ext_in;
  assign bus.timeout_reset_sel = tmo_sel;
endmodule // sba_agent

/* File: sba_arbiter.sv */
// main system bus arbiter with cpu-side port arbiter
// assumes masters follow AHB grant sampling and software programs shared channels together
// Function
// (R1) cpu ports share fifty-fifty; route memory or main
// (R2) sixteen-entry channel configuration table
// (R3) one master per channel; masters may share
// (R4) two-bit throttle: full, 3/4, half, quarter
// (R5) quarter throttle skips every third/fourth round; code passes a quarter channel only when round_cnt is 0 of 4
// (R6) configuration gates requests into pending vector
// (R7) reset: only cpu channel enabled, full rate
// (R8) evaluate each clock, hold until grant
// (R9) round-robin grant at last address/split/idle
// (R10) masters take ownership when hready high
// (R11) current master indication updates with ownership
// (R12) data ownership lags address by one transfer
// (R13) software enables shared channels together
// (R14) locked sequence blocks all other grants
// (R15) locking master kept one extra transfer
// (R16) split in lock keeps master granted
// (R17) default master granted when nobody requests
// (R18) park bus while split transfers outstanding
// (R19) default master idle too long raises timeout
// (R20) split masks master until split-complete bit
// (R21) unmasked master gets top priority next
// (R22) block requests to splitting slave
// (R23) pointer moves past granted channel
module sba_arbiter #(
  parameter int unsigned TIMEOUT_CYC = sba_pkg::IDLE_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  sba_if.arbiter bus
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] cfg_master(input logic [7:0] c);
    cfg_master = c[sba_pkg::CFG_MST_LSB +: 4];
  endfunction

  logic [15:0] request_pending_vector;
  logic [15:0] split_mask;
  logic [15:0] mask_now;
  logic [15:0] prio_mask;
  logic [15:0] hgrant_r;
  logic [3:0] hmaster_r;
  logic [3:0] hmaster_data_r;
  logic hmastlock_r;
  logic [3:0] rr_ptr;
  logic [3:0] chosen_ch;
  logic [3:0] chosen_mst;
  logic chosen_valid;
  logic [1:0] round_cnt;
  logic lock_extra;
  logic lock_split;
  logic [31:0] idle_cnt;
  logic timeout_r;
  logic cpu_iside_r;
  logic cpu_mem_r;
  sba_pkg::sba_state_t state;
  logic [15:0] gated_req;
  logic [15:0] throttle_ok;
  logic [15:0] masked_req;
  logic [15:0] prio_req;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel gating of requests
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gen_ch
      wire logic [7:0] c = bus.chan_cfg[g*8 +: 8]; // [R2] [R3]
      wire logic [1:0] bw = c[sba_pkg::CFG_BW_LSB +: 2];
      wire logic [3:0] m = cfg_master(c);
      // throttle by a shared 4-phase round counter; cheap, not exact per channel
      assign throttle_ok[g] = (bw == sba_pkg::BW_FULL) ? 1'b1 :
        (bw == sba_pkg::BW_3Q) ? (round_cnt != 2'h3) :
        (bw == sba_pkg::BW_HALF) ? round_cnt[0] :
        (round_cnt == 2'h0); // [R4] [R5]
      assign gated_req[g] = c[sba_pkg::CFG_EN_BIT] & bus.hbusreq[m] &
        ~bus.req_to_split_slave[m]; // [R6] [R22]
      assign masked_req[g] = request_pending_vector[g] & ~mask_now[m] & throttle_ok[g]; // [R20]
      assign prio_req[g] = masked_req[g] & prio_mask[m]; // [R21]
    end
  endgenerate

  // round-robin search from the pointer, unmasked-split masters first
  always_comb begin
    logic [3:0] idx;
    logic [15:0] pool;
    chosen_valid = 1'b0;
    chosen_ch = 4'h0;
    idx = 4'h0;
    pool = (|prio_req) ? prio_req : masked_req;
    for (int i = 15; i >= 0; i--) begin
      idx = rr_ptr + i[3:0];
      if (pool[idx]) begin
        chosen_valid = 1'b1;
        chosen_ch = idx; // [R9]
      end
    end
  end
  assign chosen_mst = cfg_master(bus.chan_cfg[chosen_ch*8 +: 8]);

  wire logic cur_locked = bus.hlock[hmaster_r];
  wire logic addr_last = bus.hready & (bus.hburst_last | (bus.htrans == sba_pkg::HTRANS_IDLE));
  wire logic split_seen = bus.hready & (bus.hresp == sba_pkg::HRESP_SPLIT);
  wire logic retry_seen = bus.hready & (bus.hresp == sba_pkg::HRESP_RETRY);
  // mask the splitting owner at the split edge too, else it is granted again
  assign mask_now = split_mask | (split_seen ? (16'h0001 << hmaster_r) : 16'h0000); // [R20]
  wire logic grant_slot = addr_last | split_seen; // [R9]
  wire logic dflt_idle = (hmaster_r == sba_pkg::DEFAULT_MASTER) &
    (bus.htrans == sba_pkg::HTRANS_IDLE);
  wire logic hold_lock = cur_locked | lock_extra | lock_split; // [R14] [R15] [R16]
  wire logic [3:0] next_owner = chosen_valid ? chosen_mst : sba_pkg::DEFAULT_MASTER; // [R17] [R18]

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      request_pending_vector <= 16'h0000;
      state <= sba_pkg::SBA_EVAL;
    end else begin
      case (state)
        sba_pkg::SBA_EVAL: begin
          request_pending_vector <= gated_req; // [R8]
          if (|gated_req) begin
            state <= sba_pkg::SBA_WAIT;
          end
        end
        sba_pkg::SBA_WAIT: begin
          if (grant_slot & ~hold_lock) begin
            state <= sba_pkg::SBA_EVAL; // [R8]
          end else if (grant_slot) begin
            state <= sba_pkg::SBA_LOCKED;
          end
        end
        default: begin
          if (~hold_lock) begin
            state <= sba_pkg::SBA_EVAL;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hmaster_r <= sba_pkg::DEFAULT_MASTER;
      hgrant_r <= 16'h8000;
      hmaster_data_r <= sba_pkg::DEFAULT_MASTER;
      hmastlock_r <= 1'b0;
      rr_ptr <= 4'h0;
      round_cnt <= 2'h0;
    end else begin
      if (bus.hready) begin
        hmaster_data_r <= hmaster_r; // [R12]
        hmastlock_r <= cur_locked;
      end
      if (grant_slot & ~hold_lock) begin
        hgrant_r <= 16'h0001 << next_owner;
        if (bus.hready) begin
          hmaster_r <= next_owner; // [R10] [R11]
        end
        if (chosen_valid) begin
          rr_ptr <= chosen_ch + 4'h1; // [R23]
        end
        round_cnt <= round_cnt + 2'h1;
      end
    end
  end

  // lock extension, split masking and priority
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lock_extra <= 1'b0;
      lock_split <= 1'b0;
      split_mask <= 16'h0000;
      prio_mask <= 16'h0000;
    end else begin
      if (cur_locked & bus.hready) begin
        lock_extra <= 1'b1;
      end else if (bus.hready & ~retry_seen) begin
        lock_extra <= 1'b0; // [R15]
      end
      if (split_seen & cur_locked) begin
        lock_split <= 1'b1;
      end else if (bus.hsplit[hmaster_r]) begin
        lock_split <= 1'b0; // [R16]
      end
      // a new split wins over a same-cycle complete
      split_mask <= (split_mask & ~bus.hsplit) |
        (split_seen ? (16'h0001 << hmaster_r) : 16'h0000); // [R20]
      if (grant_slot & ~hold_lock & chosen_valid) begin
        prio_mask <= bus.hsplit;
      end else begin
        prio_mask <= prio_mask | (split_mask & bus.hsplit); // [R21]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // default-master idle watchdog; sticky while timeout_reset_sel is set, else high only while the default master stays idle past the limit
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      idle_cnt <= 32'h0;
      timeout_r <= 1'b0;
    end else begin
      if (dflt_idle) begin
        if (idle_cnt < TIMEOUT_CYC) begin
          idle_cnt <= idle_cnt + 32'h1;
        end
      end else begin
        idle_cnt <= 32'h0;
      end
      timeout_r <= (dflt_idle & (idle_cnt >= TIMEOUT_CYC - 1)) |
        (timeout_r & bus.timeout_reset_sel); // [R19]
    end
  end

  // cpu port arbiter: alternate sides when both want the bus
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_iside_r <= 1'b1;
      cpu_mem_r <= 1'b0;
    end else begin
      if (bus.cpu_ifetch_req & bus.cpu_data_req) begin
        cpu_iside_r <= ~cpu_iside_r; // [R1]
      end else begin
        cpu_iside_r <= bus.cpu_ifetch_req;
      end
      cpu_mem_r <= bus.cpu_ext_mem & (bus.cpu_ifetch_req | bus.cpu_data_req); // [R1]
    end
  end

  assign bus.hgrant = hgrant_r;
  assign bus.hmaster = hmaster_r;
  assign bus.hmaster_data = hmaster_data_r;
  assign bus.hmastlock = hmastlock_r;
  assign bus.timeout = timeout_r;
  assign bus.cpu_iside_sel = cpu_iside_r;
  assign bus.cpu_to_mem_port = cpu_mem_r;
endmodule // sba_arbiter

/* File: sba_asserts.sv */
// concurrent checks on the signals joining arbiter and agent
// assumes one clock domain, instantiated in tb beside the sba_if instance
module sba_asserts #(
  parameter int unsigned TIMEOUT_CYC = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] hbusreq,
  input wire logic [15:0] hlock,
  input wire logic [15:0] hgrant,
  input wire logic [3:0] hmaster,
  input wire logic [3:0] hmaster_data,
  input wire logic [1:0] htrans,
  input wire logic hburst_last,
  input wire logic hready,
  input wire logic [1:0] hresp,
  input wire logic [15:0] hsplit,
  input wire logic cpu_ifetch_req,
  input wire logic cpu_data_req,
  input wire logic cpu_iside_sel,
  input wire logic timeout,
  input wire logic timeout_reset_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // shadow split mask; set wins over a same-cycle release
  logic [15:0] masked;
  logic [15:0] next_masked;
  int unsigned idle_cnt;
  wire logic split_seen = hready && (hresp == sba_pkg::HRESP_SPLIT);
  wire logic bus_idle = (hmaster == 4'hF) && (htrans == sba_pkg::HTRANS_IDLE);
  wire logic slot = hready && (hburst_last || htrans == sba_pkg::HTRANS_IDLE || split_seen);
  wire logic quiet = hbusreq == 16'h0 && hlock == 16'h0 && !cpu_ifetch_req && !cpu_data_req;
  assign next_masked = (masked & ~hsplit) | (split_seen ? (16'h1 << hmaster) : 16'h0);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      masked <= 16'h0;
      idle_cnt <= 0;
    end else begin
      masked <= next_masked;
      idle_cnt <= bus_idle ? idle_cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_grant_onehot: assert property ($onehot(hgrant))
    else $error("grant vector not one-hot");
  a_owner_match: assert property (hgrant == (16'h1 << hmaster))
    else $error("hmaster differs from grant");
  a_grant_slot: assert property ($changed(hmaster) |-> $past(slot))
    else $error("owner changed outside a grant slot");
  a_data_lag: assert property (1 |=> hmaster_data == ($past(hready) ? $past(hmaster) : $past(hmaster_data)))
    else $error("data owner not lagging address owner");
  a_lock_hold: assert property (hlock[hmaster] |=> $stable(hmaster))
    else $error("owner changed while locked");
  a_split_mask: assert property (hlock == 16'h0 && $past(hlock) == 16'h0 |-> (hgrant & masked) == 16'h0)
    else $error("split-masked master granted");
  a_idle_default: assert property ((quiet && hready && htrans == sba_pkg::HTRANS_IDLE) [*4] |=> hgrant == 16'h8000)
    else $error("default master not granted");
  a_tmo_fire: assert property (idle_cnt >= TIMEOUT_CYC + 2 |-> timeout)
    else $error("idle timeout missing");
  a_tmo_quiet: assert property (!timeout_reset_sel && idle_cnt >= 2 && idle_cnt + 3 <= TIMEOUT_CYC |-> !timeout)
    else $error("idle timeout too early");
  a_cpu_alt: assert property (cpu_ifetch_req && cpu_data_req |=> cpu_iside_sel != $past(cpu_iside_sel))
    else $error("cpu ports not alternating");
  a_cpu_one: assert property (cpu_ifetch_req != cpu_data_req |=> cpu_iside_sel == $past(cpu_ifetch_req))
    else $error("cpu single port not selected");
  cover property (split_seen);
  cover property ($rose(timeout));
  cover property (hmaster == 4'h1 ##1 hmaster == 4'h0);
endmodule // sba_asserts

/* File: sba_if.sv */
// interface joining the arbiter and the bus-side master/slave agent
// assumes both modules sit on the same mclk
interface sba_if;
  logic [15:0] hbusreq;
  logic [15:0] hlock;
  logic [15:0] hgrant;
  logic [3:0] hmaster;
  logic [3:0] hmaster_data;
  logic hmastlock;
  logic [1:0] htrans;
  logic hburst_last;
  logic hready;
  logic [1:0] hresp;
  logic [15:0] hsplit;
  logic [15:0] slave_split_busy;
  logic [15:0] req_to_split_slave;
  logic [127:0] chan_cfg;
  logic cpu_ifetch_req;
  logic cpu_data_req;
  logic cpu_ext_mem;
  logic cpu_iside_sel;
  logic cpu_to_mem_port;
  logic timeout;
  logic timeout_reset_sel;
  modport arbiter (
    input hbusreq, hlock, htrans, hburst_last, hready, hresp, hsplit,
    input slave_split_busy, req_to_split_slave, chan_cfg,
    input cpu_ifetch_req, cpu_data_req, cpu_ext_mem, timeout_reset_sel,
    output hgrant, hmaster, hmaster_data, hmastlock, cpu_iside_sel, cpu_to_mem_port,
    output timeout
  );
  modport agent (
    output hbusreq, hlock, htrans, hburst_last, hready, hresp, hsplit,
    output slave_split_busy, req_to_split_slave, chan_cfg,
    output cpu_ifetch_req, cpu_data_req, cpu_ext_mem, timeout_reset_sel,
    input hgrant, hmaster, hmaster_data, hmastlock, cpu_iside_sel, cpu_to_mem_port,
    input timeout
  );
endinterface : sba_if

/* File: sba_pkg.sv */
// constants and types shared by both ends of the system bus arbiter
// assumes one clock (mclk) and an asynchronous active-high reset
package sba_pkg;
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned NUM_MASTERS = 16;
  localparam int unsigned CH_IDX_W = 4;
  localparam int unsigned MST_W = 4;
  // channel configuration byte: enable, spare, throttle[1:0], master[3:0]
  localparam int unsigned CFG_W = 8;
  localparam int unsigned CFG_EN_BIT = 7;
  localparam int unsigned CFG_BW_LSB = 4;
  localparam int unsigned CFG_MST_LSB = 0;
  localparam logic [1:0] BW_FULL = 2'h0;
  localparam logic [1:0] BW_3Q = 2'h1;
  localparam logic [1:0] BW_HALF = 2'h2;
  localparam logic [1:0] BW_1Q = 2'h3;
  localparam logic [3:0] CPU_MASTER = 4'h0;
  localparam logic [3:0] DEFAULT_MASTER = 4'hF;
  localparam logic [7:0] CFG_CPU_RESET = 8'h80;
  localparam logic [7:0] CFG_OFF_RESET = 8'h00;
  // AHB transfer types and responses
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [1:0] HRESP_RETRY = 2'h2;
  localparam logic [1:0] HRESP_SPLIT = 2'h3;
  // idle timeout of the default master
  localparam int unsigned IDLE_TIMEOUT_US = 100;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_US * CLK_MHZ;
  // software register offsets of the master-side end
  localparam logic [3:0] REG_CFG0 = 4'h0;
  localparam logic [3:0] REG_CFG1 = 4'h1;
  localparam logic [3:0] REG_CFG2 = 4'h2;
  localparam logic [3:0] REG_CFG3 = 4'h3;
  localparam logic [3:0] REG_REQ = 4'h4;
  localparam logic [3:0] REG_LOCK = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_TMO = 4'h7;
  typedef enum logic [1:0] {SBA_EVAL, SBA_WAIT, SBA_LOCKED} sba_state_t;
endpackage : sba_pkg

/* File: tb.sv */
// self-checking bench: arbiter and agent joined through sba_if
// assumes the agent register port and a 200 MHz mclk
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 16;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0] htrans_in = 2'h0;
  logic hburst_last_in = 1'b1;
  logic hready_in = 1'b1;
  logic [1:0] hresp_in = 2'h0;
  logic [15:0] hsplit_in = 16'h0;
  logic [15:0] to_split_in = 16'h0;
  logic cpu_ifetch_in = 1'b0;
  logic cpu_data_in = 1'b0;
  logic cpu_ext_in = 1'b0;
  int fails = 0;
  int num_checks = 0;
  sba_if sb ();
  sba_arbiter #(.TIMEOUT_CYC(TMO)) u_sba_arbiter (.mclk(mclk), .reset(reset), .bus(sb));
  sba_agent u_sba_agent (.mclk(mclk), .reset(reset), .bus(sb), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .htrans_in(htrans_in), .hburst_last_in(hburst_last_in),
    .hready_in(hready_in), .hresp_in(hresp_in), .hsplit_in(hsplit_in), .split_busy_in(16'h0),
    .to_split_in(to_split_in), .cpu_ifetch_in(cpu_ifetch_in), .cpu_data_in(cpu_data_in),
    .cpu_ext_in(cpu_ext_in));
  sba_asserts #(.TIMEOUT_CYC(TMO)) u_sba_asserts (.mclk(mclk), .reset(reset),
    .hbusreq(sb.hbusreq), .hlock(sb.hlock), .hgrant(sb.hgrant), .hmaster(sb.hmaster),
    .hmaster_data(sb.hmaster_data), .htrans(sb.htrans), .hburst_last(sb.hburst_last),
    .hready(sb.hready), .hresp(sb.hresp), .hsplit(sb.hsplit), .cpu_ifetch_req(sb.cpu_ifetch_req),
    .cpu_data_req(sb.cpu_data_req), .cpu_iside_sel(sb.cpu_iside_sel), .timeout(sb.timeout),
    .timeout_reset_sel(sb.timeout_reset_sel));
  always #2.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one ns past the edge, so design updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // gap cycle after each strobe keeps one assignment per time step
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    d = rdata;
    tick(1);
  endtask
  task automatic wait_on(input bit tmo, input logic [3:0] v, input int lim);
    logic [3:0] s;
    for (int i = 0; i < lim; i++) begin
      s = tmo ? {3'h0, sb.timeout} : sb.hmaster;
      if (s === v) return;
      tick(1);
    end
    chk("wait", 32'(s), 32'(v));
    final_report();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    chk("grant_rst", 32'(sb.hgrant), 32'h8000);
    rd_reg(sba_pkg::REG_STATUS, d);
    chk("status_rst", d, 32'h0000FF00);
    rd_reg(sba_pkg::REG_CFG0, d);
    chk("cfg0_rst", d, 32'h00000080);
    rd_reg(sba_pkg::REG_CFG3, d);
    chk("cfg3_rst", d, 32'h0);
    wr_reg(4'h9, 32'hFFFFFFFF);
    rd_reg(4'h9, d);
    chk("unmapped", d, 32'h0);
    rd_reg(sba_pkg::REG_CFG0, d);
    chk("cfg0_keep", d, 32'h00000080);
  endtask
  // masters 0 and 1 alternate; master 2 has no channel
  task automatic t_rr();
    logic [3:0] last;
    int turns;
    int n2;
    wr_reg(sba_pkg::REG_CFG0, 32'h00008180);
    wr_reg(sba_pkg::REG_REQ, 32'h7);
    wait_on(0, 4'h1, 8);
    last = 4'h1;
    turns = 0;
    n2 = 0;
    repeat (20) begin
      tick(1);
      n2 += int'(sb.hgrant[2] !== 1'b0);
      if (sb.hmaster !== last) begin
        chk("rr_order", 32'(sb.hmaster), 32'(last ^ 4'h1));
        last = sb.hmaster;
        turns++;
      end
    end
    chk("rr_turns", 32'(turns >= 4), 32'h1);
    chk("no_channel", 32'(n2), 32'h0);
  endtask
  // lone requester on each throttle level
  task automatic t_bw();
    int n1;
    for (int bw = 0; bw < 4; bw++) begin
      wr_reg(sba_pkg::REG_CFG0, 32'h00008180 | (32'(bw) << 12));
      wr_reg(sba_pkg::REG_REQ, 32'h2);
      tick(4);
      n1 = 0;
      repeat (40) begin
        tick(1);
        n1 += int'(sb.hmaster === 4'h1);
      end
      if (bw == 0) chk("bw_full", 32'(n1), 32'd40);
      else chk("bw_cut", 32'(n1), 32'(10 * (4 - bw)));
    end
    wr_reg(sba_pkg::REG_CFG0, 32'h00008180);
  endtask
  task automatic t_lock();
    logic [31:0] d;
    wr_reg(sba_pkg::REG_REQ, 32'h3);
    wr_reg(sba_pkg::REG_LOCK, 32'h2);
    wait_on(0, 4'h1, 10);
    repeat (8) begin
      tick(1);
      chk("lock_hold", 32'(sb.hmaster), 32'h1);
    end
    rd_reg(sba_pkg::REG_STATUS, d);
    chk("lock_flag", 32'(d[16]), 32'h1);
    wr_reg(sba_pkg::REG_LOCK, 32'h0);
    chk("lock_extra", 32'(sb.hmaster), 32'h1);
    wait_on(0, 4'h0, 8);
  endtask
  task automatic t_split();
    wr_reg(sba_pkg::REG_REQ, 32'h2);
    htrans_in <= sba_pkg::HTRANS_NONSEQ;
    wait_on(0, 4'h1, 10);
    tick(2);
    hresp_in <= sba_pkg::HRESP_SPLIT;
    tick(1);
    hresp_in <= sba_pkg::HRESP_OKAY;
    tick(2);
    chk("park", 32'(sb.hgrant), 32'h8000);
    wr_reg(sba_pkg::REG_REQ, 32'h3);
    repeat (6) begin
      tick(1);
      chk("split_mask", 32'(sb.hgrant[1]), 32'h0);
    end
    hsplit_in <= 16'h0002;
    tick(1);
    hsplit_in <= 16'h0;
    wait_on(0, 4'h1, 4);
    to_split_in <= 16'h0001;
    tick(3);
    repeat (6) begin
      tick(1);
      chk("split_slave", 32'(sb.hgrant[0]), 32'h0);
    end
    to_split_in <= 16'h0;
  endtask
  task automatic t_idle();
    logic [31:0] d;
    htrans_in <= sba_pkg::HTRANS_IDLE;
    wr_reg(sba_pkg::REG_REQ, 32'h0);
    wait_on(0, 4'hF, 6);
    tick(TMO - 4);
    chk("tmo_early", 32'(sb.timeout), 32'h0);
    wait_on(1, 4'h1, 10);
    htrans_in <= sba_pkg::HTRANS_NONSEQ;
    wr_reg(sba_pkg::REG_REQ, 32'h2);
    wait_on(1, 4'h0, 8);
    wr_reg(sba_pkg::REG_TMO, 32'h1);
    htrans_in <= sba_pkg::HTRANS_IDLE;
    wr_reg(sba_pkg::REG_REQ, 32'h0);
    wait_on(1, 4'h1, TMO + 10);
    htrans_in <= sba_pkg::HTRANS_NONSEQ;
    wr_reg(sba_pkg::REG_REQ, 32'h2);
    tick(4);
    rd_reg(sba_pkg::REG_STATUS, d);
    chk("tmo_sticky", 32'(d[17]), 32'h1);
    wr_reg(sba_pkg::REG_TMO, 32'h0);
    tick(2);
    chk("tmo_clear", 32'(sb.timeout), 32'h0);
  endtask
  task automatic t_cpu();
    logic s;
    cpu_ifetch_in <= 1'b1;
    cpu_data_in <= 1'b1;
    cpu_ext_in <= 1'b1;
    tick(2);
    s = sb.cpu_iside_sel;
    tick(1);
    chk("cpu_alt", 32'(sb.cpu_iside_sel != s), 32'h1);
    cpu_data_in <= 1'b0;
    tick(2);
    chk("cpu_ifetch", 32'(sb.cpu_iside_sel), 32'h1);
    cpu_ifetch_in <= 1'b0;
    cpu_data_in <= 1'b1;
    tick(2);
    chk("cpu_data", 32'(sb.cpu_iside_sel), 32'h0);
    chk("cpu_mem", 32'(sb.cpu_to_mem_port), 32'h1);
    cpu_ext_in <= 1'b0;
    tick(2);
    chk("cpu_main", 32'(sb.cpu_to_mem_port), 32'h0);
    cpu_data_in <= 1'b0;
    tick(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    tick(1);
    t_reset();
    t_rr();
    t_bw();
    t_lock();
    t_split();
    t_idle();
    t_cpu();
    final_report();
  end
endmodule // tb
